// [verilog/rmc_mode_ctrl.v]
// host-side mode register controller: issues mode-set commands and guards their timing
//
// What this block does
// - after a valid mode-set, wait the recovery time before any other command
// - back-to-back dummy mode-sets for power-up reset skip the recovery wait
// - issue mode-set only while every bank is idle
// - changing burst length makes earlier stored data invalid
// - drive address bits ten to seventeen low; bit six is ignored
// - never program burst eight with setup one or setup four
// - three-cycle setup needs four cycles for write then read same bank
// - burst eight on the 36-bit width only with the later die
// - multiplexed address goes out in two parts on successive edges
// - bank address travels with the command and first address part
// - refresh has no second part, so refreshes may run back to back
// - multiplexed mode costs bus efficiency only at burst length two
// - after DLL enable, wait 1024 cycles before any read
// - on clock or supply change: DLL off, recover, DLL on, wait 1024
`timescale 1ns/1ns
`include "rmc_consts.vh"

module rmc_mode_ctrl (
   // clock, reset, enable
   input  wire                    CLK,
   input  wire                    RESET,
   input  wire                    CE,
   // software register port
   input  wire [7:0]              REG_ADDR,
   input  wire [31:0]             REG_WDATA,
   input  wire                    REG_WR,
   input  wire                    REG_RD,
   output reg  [31:0]             REG_RDATA,
   // state of the rest of the memory controller
   input  wire                    BANKS_IDLE,
   // device command and address pins
   output reg                     MEM_CS_N,
   output reg                     MEM_WE_N,
   output reg                     MEM_REF_N,
   output reg  [`RMC_ADDR_W-1:0]  MEM_ADDR,
   output reg  [2:0]              MEM_BA,
   // holds and settings for the command scheduler
   output wire                    CMD_HOLD,
   output wire                    READ_HOLD,
   output reg  [3:0]              READ_LATENCY,
   output reg  [3:0]              WRITE_LATENCY,
   output reg  [3:0]              ROW_CYCLE,
   output reg  [3:0]              WR_RD_ROW_CYCLE,
   output reg  [3:0]              BURST_LEN,
   output reg  [4:0]              ADDR_MSB,
   output reg                     ADDR_SPLIT,
   output reg                     DLL_ON,
   output reg                     DRIVE_EXTERNAL,
   output reg                     TERMINATION_ON
);

   // ****************************************************************
   // states
   // ****************************************************************
   localparam [2:0] ST_IDLE    = 3'h0;
   localparam [2:0] ST_WAIT    = 3'h1;
   localparam [2:0] ST_FIRST   = 3'h2;
   localparam [2:0] ST_SECOND  = 3'h3;
   localparam [2:0] ST_RECOVER = 3'h4;

   // ****************************************************************
   // declarations
   // ****************************************************************
   reg  [2:0]             state_reg;
   reg  [2:0]             state_next;
   reg  [`RMC_MODE_W-1:0] staged_reg;
   reg  [`RMC_MODE_W-1:0] pending_reg;
   reg  [`RMC_MODE_W-1:0] applied_reg;
   reg  [1:0]             org_reg;
   reg                    late_die_reg;
   reg                    dummy_reg;
   reg                    refused_reg;
   reg                    stale_reg;
   reg                    start_recovery;
   reg                    start_lock;
   wire                   recovering;
   wire                   locking;
   wire                   legal;
   wire [3:0]             dec_rl;
   wire [3:0]             dec_wl;
   wire [3:0]             dec_rc;
   wire [3:0]             dec_wrrd;
   wire [3:0]             dec_bl;
   wire [4:0]             dec_msb;
   wire                   busy;
   wire                   cmd_wr;
   wire                   issue_req;
   wire                   dummy_req;
   wire                   accept;
   wire                   refuse;
   wire                   applying;
   wire [`RMC_MODE_W-1:0] clean_word;

   // bits 10..17 and the unused bit go out low
   function [`RMC_MODE_W-1:0] scrub;
      input [`RMC_MODE_W-1:0] w;
      begin
         scrub = w & `RMC_LIVE_MASK;
      end
   endfunction

   // register port decode, shared by write and read paths
   function hit;
      input [7:0] a;
      input [7:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   assign busy       = (state_reg != ST_IDLE);
   assign cmd_wr     = REG_WR && hit(REG_ADDR, `RMC_OFF_CMD);
   assign issue_req  = cmd_wr && REG_WDATA[`RMC_CMD_ISSUE];
   assign dummy_req  = cmd_wr && REG_WDATA[`RMC_CMD_DUMMY] && !REG_WDATA[`RMC_CMD_ISSUE];
   // a valid mode-set with an illegal combination never reaches the pins
   assign accept     = !busy && (dummy_req || (issue_req && legal));
   assign refuse     = cmd_wr && (REG_WDATA[`RMC_CMD_ISSUE] || REG_WDATA[`RMC_CMD_DUMMY])
                       && !accept;
   assign applying   = (state_reg == ST_RECOVER) && !recovering && !start_recovery;
   assign clean_word = scrub(staged_reg);

   // other commands wait for the whole mode-set and its recovery
   assign CMD_HOLD   = busy;
   assign READ_HOLD  = busy || locking;

   // ****************************************************************
   // decoding and timers
   // ****************************************************************
   rmc_mode_decode u_decode (
      .mode_word       (staged_reg),
      .org             (org_reg),
      .late_die        (late_die_reg),
      .read_latency    (),
      .write_latency   (),
      .row_cycle       (),
      .wr_rd_row_cycle (),
      .burst_len       (),
      .addr_msb        (),
      .legal           (legal)
   );

   rmc_mode_decode u_applied (
      .mode_word       (applied_reg),
      .org             (org_reg),
      .late_die        (late_die_reg),
      .read_latency    (dec_rl),
      .write_latency   (dec_wl),
      .row_cycle       (dec_rc),
      .wr_rd_row_cycle (dec_wrrd),
      .burst_len       (dec_bl),
      .addr_msb        (dec_msb),
      .legal           ()
   );

   rmc_wait_timer u_recovery (
      .CLK        (CLK),
      .RESET      (RESET),
      .CE         (CE),
      .load       (start_recovery),
      .load_value (`RMC_RECOVERY_CYC),
      .busy       (recovering)
   );

   rmc_wait_timer u_lock (
      .CLK        (CLK),
      .RESET      (RESET),
      .CE         (CE),
      .load       (start_lock),
      .load_value (`RMC_LOCK_CYC),
      .busy       (locking)
   );

   // ****************************************************************
   // sequencer
   // ****************************************************************
   always @* begin
      state_next     = state_reg;
      start_recovery = 1'b0;
      start_lock     = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (accept) begin
               state_next = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (BANKS_IDLE) begin
               state_next = ST_FIRST;
            end
         end
         ST_FIRST: begin
            // the format follows the mode in force, not the one being sent
            if (applied_reg[`RMC_SPLIT_BIT] && !dummy_reg) begin
               state_next = ST_SECOND;
            end else if (dummy_reg) begin
               state_next = ST_IDLE;
            end else begin
               state_next     = ST_RECOVER;
               start_recovery = 1'b1;
               start_lock     = pending_reg[`RMC_LOCK_BIT];
            end
         end
         ST_SECOND: begin
            state_next     = ST_RECOVER;
            start_recovery = 1'b1;
            start_lock     = pending_reg[`RMC_LOCK_BIT];
         end
         ST_RECOVER: begin
            if (applying) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge CLK) begin
      if (RESET) begin
         state_reg   <= ST_IDLE;
         pending_reg <= `RMC_MODE_RESET;
         applied_reg <= `RMC_MODE_RESET;
         dummy_reg   <= 1'b0;
         stale_reg   <= 1'b0;
      end else if (CE) begin
         state_reg <= state_next;
         if (accept) begin
            // dummies carry an all-low address
            pending_reg <= dummy_req ? `RMC_MODE_RESET : clean_word;
            dummy_reg   <= dummy_req;
         end
         if (applying) begin
            applied_reg <= pending_reg;
         end
         // set wins over a software clear in the same cycle
         if (applying && (pending_reg[`RMC_BURST_MSB:`RMC_BURST_LSB]
                          != applied_reg[`RMC_BURST_MSB:`RMC_BURST_LSB])) begin
            stale_reg <= 1'b1;
         end else if (REG_WR && hit(REG_ADDR, `RMC_OFF_STATUS)
                      && REG_WDATA[`RMC_ST_STALE]) begin
            stale_reg <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // device pins
   // ****************************************************************
   always @(posedge CLK) begin
      if (RESET) begin
         MEM_CS_N  <= 1'b1;
         MEM_WE_N  <= 1'b1;
         MEM_REF_N <= 1'b1;
         MEM_ADDR  <= {`RMC_ADDR_W{1'b0}};
         MEM_BA    <= 3'h0;
      end else if (CE) begin
         MEM_CS_N  <= 1'b1;
         MEM_WE_N  <= 1'b1;
         MEM_REF_N <= 1'b1;
         MEM_ADDR  <= {`RMC_ADDR_W{1'b0}};
         MEM_BA    <= 3'h0;
         if (state_reg == ST_WAIT && BANKS_IDLE) begin
            MEM_CS_N  <= 1'b0;
            MEM_WE_N  <= 1'b0;
            MEM_REF_N <= 1'b0;
            if (applied_reg[`RMC_SPLIT_BIT] && !dummy_reg) begin
               // first part: low eleven mode bits on the eleven pins
               MEM_ADDR[`RMC_SPLIT_PINS-1:0] <=
                  pending_reg[`RMC_SPLIT_PINS-1:0];
            end else begin
               MEM_ADDR[`RMC_MODE_W-1:0] <= pending_reg;
            end
         end else if (state_reg == ST_FIRST && applied_reg[`RMC_SPLIT_BIT] && !dummy_reg) begin
            // second part rides a deselect cycle on the next edge
            MEM_ADDR[`RMC_MODE_W-`RMC_SPLIT_PINS-1:0] <=
               pending_reg[`RMC_MODE_W-1:`RMC_SPLIT_PINS];
         end
      end
   end

   // ****************************************************************
   // settings for the scheduler, from the applied word
   // ****************************************************************
   always @(posedge CLK) begin
      if (RESET) begin
         READ_LATENCY    <= `RMC_RC_CFG1;
         WRITE_LATENCY   <= `RMC_RC_CFG1 + `RMC_WL_EXTRA;
         ROW_CYCLE       <= `RMC_RC_CFG1;
         WR_RD_ROW_CYCLE <= `RMC_RC_CFG1;
         BURST_LEN       <= 4'h2;
         ADDR_MSB        <= `RMC_AMSB_X9;
         ADDR_SPLIT      <= 1'b0;
         DLL_ON          <= 1'b0;
         DRIVE_EXTERNAL  <= 1'b0;
         TERMINATION_ON  <= 1'b0;
      end else if (CE) begin
         READ_LATENCY    <= dec_rl;
         WRITE_LATENCY   <= dec_wl;
         ROW_CYCLE       <= dec_rc;
         WR_RD_ROW_CYCLE <= dec_wrrd;
         BURST_LEN       <= dec_bl;
         ADDR_MSB        <= dec_msb;
         ADDR_SPLIT      <= applied_reg[`RMC_SPLIT_BIT];
         DLL_ON          <= applied_reg[`RMC_LOCK_BIT];
         DRIVE_EXTERNAL  <= applied_reg[`RMC_DRIVE_BIT];
         TERMINATION_ON  <= applied_reg[`RMC_TERM_BIT];
      end
   end

   // ****************************************************************
   // software registers
   // ****************************************************************
   always @(posedge CLK) begin
      if (RESET) begin
         staged_reg   <= `RMC_MODE_RESET;
         org_reg      <= `RMC_ORG_X9;
         late_die_reg <= 1'b0;
         refused_reg  <= 1'b0;
         REG_RDATA    <= 32'h0000_0000;
      end else if (CE) begin
         if (REG_WR && hit(REG_ADDR, `RMC_OFF_MODE)) begin
            staged_reg <= REG_WDATA[`RMC_MODE_W-1:0];
         end
         if (REG_WR && hit(REG_ADDR, `RMC_OFF_ORG)) begin
            org_reg      <= REG_WDATA[`RMC_ORG_MSB:`RMC_ORG_LSB];
            late_die_reg <= REG_WDATA[`RMC_ORG_LATE_DIE];
         end
         if (refuse) begin
            refused_reg <= 1'b1;
         end else if (REG_WR && hit(REG_ADDR, `RMC_OFF_STATUS)
                      && REG_WDATA[`RMC_ST_REFUSED]) begin
            refused_reg <= 1'b0;
         end
         REG_RDATA <= 32'h0000_0000;
         if (REG_RD) begin
            if (hit(REG_ADDR, `RMC_OFF_MODE)) begin
               REG_RDATA[`RMC_MODE_W-1:0] <= staged_reg;
            end else if (hit(REG_ADDR, `RMC_OFF_STATUS)) begin
               REG_RDATA[`RMC_ST_BUSY]    <= busy;
               REG_RDATA[`RMC_ST_RECOVER] <= recovering;
               REG_RDATA[`RMC_ST_LOCKING] <= locking;
               REG_RDATA[`RMC_ST_REFUSED] <= refused_reg;
               REG_RDATA[`RMC_ST_STALE]   <= stale_reg;
               REG_RDATA[`RMC_ST_SPLIT]   <= applied_reg[`RMC_SPLIT_BIT];
            end else if (hit(REG_ADDR, `RMC_OFF_APPLIED)) begin
               REG_RDATA[`RMC_MODE_W-1:0] <= applied_reg;
            end else if (hit(REG_ADDR, `RMC_OFF_ORG)) begin
               REG_RDATA[`RMC_ORG_MSB:`RMC_ORG_LSB] <= org_reg;
               REG_RDATA[`RMC_ORG_LATE_DIE]         <= late_die_reg;
            end
         end
      end
   end

endmodule // rmc_mode_ctrl

// [verilog/rmc_consts.vh]
// constants for the mode register controller: register map, fields, timing counts
`ifndef RMC_CONSTS_VH
`define RMC_CONSTS_VH

// ****************************************************************
// software register map (byte addresses)
// ****************************************************************
`define RMC_OFF_MODE       8'h00
`define RMC_OFF_CMD        8'h04
`define RMC_OFF_STATUS     8'h08
`define RMC_OFF_APPLIED    8'h0C
`define RMC_OFF_ORG        8'h10

// command register bits
`define RMC_CMD_ISSUE      0
`define RMC_CMD_DUMMY      1

// status register bits
`define RMC_ST_BUSY        0
`define RMC_ST_RECOVER     1
`define RMC_ST_LOCKING     2
`define RMC_ST_REFUSED     3
`define RMC_ST_STALE       4
`define RMC_ST_SPLIT       5

// organisation register fields
`define RMC_ORG_LSB        0
`define RMC_ORG_MSB        1
`define RMC_ORG_LATE_DIE   2
`define RMC_ORG_X9         2'h0
`define RMC_ORG_X18        2'h1
`define RMC_ORG_X36        2'h2

// ****************************************************************
// mode word layout
// ****************************************************************
`define RMC_MODE_W         18
`define RMC_MODE_RESET     18'h0_0000
`define RMC_CFG_LSB        0
`define RMC_CFG_MSB        2
`define RMC_BURST_LSB      3
`define RMC_BURST_MSB      4
`define RMC_SPLIT_BIT      5
`define RMC_UNUSED_BIT     6
`define RMC_LOCK_BIT       7
`define RMC_DRIVE_BIT      8
`define RMC_TERM_BIT       9
`define RMC_ZERO_LSB       10
`define RMC_ZERO_MSB       17
`define RMC_LIVE_MASK      18'h0_03BF

// configuration codes and burst codes
`define RMC_CFG_1          3'h1
`define RMC_CFG_2          3'h2
`define RMC_CFG_3          3'h3
`define RMC_CFG_4          3'h4
`define RMC_CFG_5          3'h5
`define RMC_BURST_2        2'h0
`define RMC_BURST_4        2'h1
`define RMC_BURST_8        2'h2

// cycle figures per configuration
`define RMC_RC_CFG1        4'h4
`define RMC_RC_CFG2        4'h6
`define RMC_RC_CFG3        4'h8
`define RMC_RC_CFG4        4'h3
`define RMC_RC_CFG5        4'h5
`define RMC_RC_WR_RD_CFG4  4'h4
`define RMC_WL_EXTRA       4'h1

// address msb for burst 2 per width; one fewer per doubling
`define RMC_AMSB_X9        5'h14
`define RMC_AMSB_X18       5'h13
`define RMC_AMSB_X36       5'h12

// multiplexed address: pins used per part
`define RMC_SPLIT_PINS     11
`define RMC_ADDR_W         21

// ****************************************************************
// timing counts in CK cycles
// ****************************************************************
`define RMC_TIMER_W        11
`define RMC_RECOVERY_CYC   11'h006
`define RMC_LOCK_CYC       11'h400

`endif

// [verilog/rmc_wait_timer.v]
// down-counting wait timer: busy while a loaded count runs out
`timescale 1ns/1ns
`include "rmc_consts.vh"

module rmc_wait_timer (
   // clock and reset
   input  wire                    CLK,
   input  wire                    RESET,
   input  wire                    CE,
   // control
   input  wire                    load,
   input  wire [`RMC_TIMER_W-1:0] load_value,
   output wire                    busy
);

   reg [`RMC_TIMER_W-1:0] count_reg;

   assign busy = (count_reg != {`RMC_TIMER_W{1'b0}});

   always @(posedge CLK) begin
      if (RESET) begin
         count_reg <= {`RMC_TIMER_W{1'b0}};
      end else if (CE) begin
         if (load) begin
            count_reg <= load_value;
         end else if (busy) begin
            count_reg <= count_reg - {{(`RMC_TIMER_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // rmc_wait_timer

// [verilog/rmc_mode_decode.v]
// decodes a mode word into latencies, burst length, address width and legality
`timescale 1ns/1ns
`include "rmc_consts.vh"

module rmc_mode_decode (
   // mode word and organisation
   input  wire [`RMC_MODE_W-1:0] mode_word,
   input  wire [1:0]             org,
   input  wire                   late_die,
   // decoded settings
   output reg  [3:0]             read_latency,
   output wire [3:0]             write_latency,
   output wire [3:0]             row_cycle,
   output reg  [3:0]             wr_rd_row_cycle,
   output reg  [3:0]             burst_len,
   output reg  [4:0]             addr_msb,
   output wire                   legal
);

   wire [2:0] cfg   = mode_word[`RMC_CFG_MSB:`RMC_CFG_LSB];
   wire [1:0] burst = mode_word[`RMC_BURST_MSB:`RMC_BURST_LSB];
   reg        cfg_ok;
   reg        burst_ok;
   reg  [4:0] base_msb;

   always @* begin
      cfg_ok          = 1'b1;
      wr_rd_row_cycle = `RMC_RC_CFG1;
      case (cfg)
         `RMC_CFG_1: read_latency = `RMC_RC_CFG1;
         `RMC_CFG_2: read_latency = `RMC_RC_CFG2;
         `RMC_CFG_3: read_latency = `RMC_RC_CFG3;
         `RMC_CFG_4: read_latency = `RMC_RC_CFG4;
         `RMC_CFG_5: read_latency = `RMC_RC_CFG5;
         default: begin
            read_latency = `RMC_RC_CFG1;
            cfg_ok       = 1'b0;
         end
      endcase
      // three-cycle setup needs one more cycle for write then read, same bank
      if (cfg == `RMC_CFG_4) begin
         wr_rd_row_cycle = `RMC_RC_WR_RD_CFG4;
      end else begin
         wr_rd_row_cycle = read_latency;
      end
   end

   assign row_cycle     = read_latency;
   assign write_latency = read_latency + `RMC_WL_EXTRA;

   always @* begin
      case (org)
         `RMC_ORG_X18: base_msb = `RMC_AMSB_X18;
         `RMC_ORG_X36: base_msb = `RMC_AMSB_X36;
         default:      base_msb = `RMC_AMSB_X9;
      endcase
      burst_ok = 1'b1;
      case (burst)
         `RMC_BURST_2: begin
            burst_len = 4'h2;
            addr_msb  = base_msb;
         end
         `RMC_BURST_4: begin
            burst_len = 4'h4;
            addr_msb  = base_msb - 5'h01;
         end
         `RMC_BURST_8: begin
            burst_len = 4'h8;
            addr_msb  = base_msb - 5'h02;
            // no burst 8 with the two shortest row-cycle setups
            if (cfg == `RMC_CFG_1 || cfg == `RMC_CFG_4) begin
               burst_ok = 1'b0;
            end
            if (org == `RMC_ORG_X36 && !late_die) begin
               burst_ok = 1'b0;
            end
         end
         default: begin
            burst_len = 4'h2;
            addr_msb  = base_msb;
            burst_ok  = 1'b0;
         end
      endcase
   end

   assign legal = cfg_ok & burst_ok;

endmodule // rmc_mode_decode

// [sim/rmc_monitor.sv]
// checker for the mode register controller pins and settings
`timescale 1ns/1ns
module rmc_monitor (
   // clock and reset
   input wire        CLK,
   input wire        RESET,
   // pins and settings
   input wire        BANKS_IDLE,
   input wire        MEM_CS_N,
   input wire        MEM_WE_N,
   input wire        MEM_REF_N,
   input wire [20:0] MEM_ADDR,
   input wire        CMD_HOLD,
   input wire        READ_HOLD,
   input wire [3:0]  READ_LATENCY,
   input wire [3:0]  WRITE_LATENCY,
   input wire [3:0]  ROW_CYCLE,
   input wire [3:0]  BURST_LEN,
   input wire        ADDR_SPLIT,
   input wire        DLL_ON
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   wire ms = !MEM_CS_N && !MEM_WE_N && !MEM_REF_N;
   AST_ONE: assert property (ms |=> MEM_CS_N) else $error("long mode-set");
   AST_ZERO: assert property (ms |-> MEM_ADDR[17:10] == 8'h00 && !MEM_ADDR[6])
      else $error("mode-set address not scrubbed");
   AST_HOLD: assert property (ms |-> CMD_HOLD) else $error("mode-set without hold");
   AST_IDLE: assert property (ms |-> $past(BANKS_IDLE)) else $error("banks busy");
   AST_WL: assert property (WRITE_LATENCY == READ_LATENCY + 4'h1) else $error("wl");
   AST_RC: assert property (ROW_CYCLE == READ_LATENCY) else $error("row cycle");
   AST_RDH: assert property (CMD_HOLD |-> READ_HOLD) else $error("read hold");
   AST_STAB: assert property (!$past(CMD_HOLD, 2) |-> $stable(BURST_LEN))
      else $error("setting changed outside a mode-set");
   AST_MUX: assert property (ms && ADDR_SPLIT |-> MEM_ADDR[20:11] == 10'h000)
      else $error("split part too wide");
   AST_LOCK: assert property ($rose(DLL_ON) |-> READ_HOLD) else $error("lock");
endmodule // rmc_monitor
bind rmc_mode_ctrl rmc_monitor i_mon (.*);

// [sim/rmc_dev_model.sv]
// behavioural device end: holds the mode word taken from the pins
`timescale 1ns/1ns
module rmc_dev_model (
   // command and address pins
   input wire        CLK,
   input wire        MEM_CS_N,
   input wire        MEM_WE_N,
   input wire        MEM_REF_N,
   input wire [20:0] MEM_ADDR,
   // captured mode word
   output reg [17:0] DEV_MODE = 18'h0_0000
);
   reg        part2_reg = 1'b0;
   reg [10:0] low_reg   = 11'h000;
   always @(posedge CLK) begin
      part2_reg <= 1'b0;
      if (part2_reg)
         DEV_MODE <= {MEM_ADDR[6:0], low_reg} & 18'h0_03BF;
      // split format follows the word in force; bits 6 and 10..17 are dropped
      if (!MEM_CS_N && !MEM_WE_N && !MEM_REF_N) begin
         if (DEV_MODE[5]) begin
            low_reg <= MEM_ADDR[10:0];
            part2_reg <= 1'b1;
         end else
            DEV_MODE <= MEM_ADDR[17:0] & 18'h0_03BF;
      end
   end
endmodule // rmc_dev_model

// [sim/mode_register_config_bench.sv]
// self-checking bench for the mode register controller
`timescale 1ns/1ns
`include "rmc_consts.vh"
module mode_register_config_bench;
   reg         CLK = 1'b0, RESET = 1'b1, CE = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
   reg         BANKS_IDLE = 1'b1;
   reg  [7:0]  REG_ADDR = 8'h00;
   reg  [31:0] REG_WDATA = 32'h0000_0000, d;
   wire [31:0] REG_RDATA;
   wire        MEM_CS_N, MEM_WE_N, MEM_REF_N, CMD_HOLD, READ_HOLD, ADDR_SPLIT, DLL_ON;
   wire        DRIVE_EXTERNAL, TERMINATION_ON;
   wire [20:0] MEM_ADDR;
   wire [17:0] DEV_MODE;
   wire [2:0]  MEM_BA;
   wire [3:0]  READ_LATENCY, WRITE_LATENCY, ROW_CYCLE, WR_RD_ROW_CYCLE, BURST_LEN;
   wire [4:0]  ADDR_MSB;
   integer     n_errors = 0, total_checks = 0, i, k;
   localparam [23:0] RLT = 24'h53_8640;
   rmc_mode_ctrl i_dut (.*);
   rmc_dev_model i_dev (.*);
   always #2 CLK = ~CLK;
   task chk(input [47:0] nm, input [31:0] seen, input [31:0] exp); begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("mismatch %0s expected %h seen %h", nm, exp, seen);
      end
   end endtask
   task stop_test; begin
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   end endtask
   task wr(input [7:0] a, input [31:0] v); begin
      @(posedge CLK);
      REG_ADDR <= a;
      REG_WDATA <= v;
      REG_WR <= 1'b1;
      @(posedge CLK);
      REG_WR <= 1'b0;
   end endtask
   task rd(input [7:0] a); begin
      @(posedge CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1 d = REG_RDATA;
   end endtask
   // hold may never rise for a refused word, so the wait starts late
   task wt; begin
      repeat (3) @(posedge CLK) #1;
      for (k = 0; k < 40 && CMD_HOLD !== 1'b0; k = k + 1) @(posedge CLK) #1;
      if (k == 40) begin
         n_errors = n_errors + 1;
         stop_test;
      end
      repeat (2) @(posedge CLK) #1;
   end endtask
   task go(input [17:0] w); begin
      wr(`RMC_OFF_MODE, {14'h0000, w});
      wr(`RMC_OFF_CMD, 32'h0000_0001);
   end endtask
   initial begin
      repeat (12) @(posedge CLK);
      RESET <= 1'b0;
      #1 chk("wl", WRITE_LATENCY, 4'h5);
      chk("msb", {ADDR_MSB, BURST_LEN}, 9'h142);
      for (i = 1; i < 6; i = i + 1) begin
         go(18'h3_FF48 | i[2:0]);
         wt;
         chk("dev", DEV_MODE, 18'h0_0308 | i[2:0]);
         chk("rl", {READ_LATENCY, ROW_CYCLE}, {2{RLT[i*4+:4]}});
         chk("wrrd", WR_RD_ROW_CYCLE, (i == 4) ? 4'h4 : RLT[i*4+:4]);
         chk("msb", ADDR_MSB, 5'h13);
      end
      chk("opts", {DRIVE_EXTERNAL, TERMINATION_ON, BURST_LEN}, 6'h34);
      rd(`RMC_OFF_STATUS);
      chk("stale", d, 32'h0000_0010);
      wr(`RMC_OFF_STATUS, 32'h0000_0018);
      $display("config test done");
      go(18'h0_0011);
      wt;
      rd(`RMC_OFF_STATUS);
      chk("refuse", d, 32'h0000_0008);
      chk("keep", DEV_MODE, 18'h0_030D);
      wr(`RMC_OFF_ORG, 32'h0000_0002);
      // clear the sticky flag so the next refusal has to set it afresh
      wr(`RMC_OFF_STATUS, 32'h0000_0008);
      go(18'h0_0012);
      wt;
      rd(`RMC_OFF_STATUS);
      chk("x36", d[3], 1'b1);
      wr(`RMC_OFF_ORG, 32'h0000_0006);
      go(18'h0_0012);
      wt;
      chk("b8", {ADDR_MSB, BURST_LEN}, 9'h108);
      rd(8'h20);
      chk("hole", d, 32'h0000_0000);
      @(posedge CLK) BANKS_IDLE <= 1'b0;
      go(18'h0_00A2);
      repeat (8) @(posedge CLK);
      chk("busy", DEV_MODE, 18'h0_0012);
      BANKS_IDLE <= 1'b1;
      wt;
      chk("dll", {READ_HOLD, ADDR_SPLIT, DLL_ON}, 3'h7);
      chk("ba", MEM_BA, 3'h0);
      for (k = 0; k < 1100 && READ_HOLD; k = k + 1) @(posedge CLK) #1;
      chk("lock", k > 1000 && k < 1030, 1'b1);
      go(18'h0_03A3);
      wt;
      chk("split", DEV_MODE, 18'h0_03A3);
      wr(`RMC_OFF_STATUS, 32'h0000_0008);
      wr(`RMC_OFF_CMD, 32'h0000_0002);
      repeat (3) @(posedge CLK);
      wr(`RMC_OFF_CMD, 32'h0000_0002);
      repeat (4) @(posedge CLK) #1;
      chk("dummy", DEV_MODE, 18'h0_0000);
      // a recovery wait after the first dummy would have refused the second
      rd(`RMC_OFF_STATUS);
      chk("dummy2", d[3], 1'b0);
      // writes taken while the enable is low must leave the registers alone
      @(posedge CLK) CE <= 1'b0;
      wr(`RMC_OFF_ORG, 32'h0000_0001);
      CE <= 1'b1;
      rd(`RMC_OFF_ORG);
      chk("freeze", d, 32'h0000_0006);
      $display("mode test done");
      stop_test;
   end
endmodule // mode_register_config_bench
